// ==== core/hall_readout_regs.svh ====
`ifndef HALL_READOUT_REGS_SVH
`define HALL_READOUT_REGS_SVH

// ==========================================================
// register indices on the output-line command channel
`define REG_TEMPERATURE 5'h00
`define REG_RAW_FIELD 5'h01
`define REG_FACTORY_COMP 5'h02
`define REG_CUSTOMER_COMP 5'h03
`define REG_LIN_INPUT 5'h04
`define REG_LIN_OUTPUT 5'h05
`define REG_SCALED_OUTPUT 5'h06
`define REG_OUTPUT_CODE 5'h07
`define REG_PROD_INFO_1 5'h08
`define REG_PROD_INFO_2 5'h09
`define REG_CUSTOMER_SETUP 5'h0a
`define REG_LOCK 5'h0b
`define REG_STATUS 5'h0c

// ==========================================================
// field positions and reset values
`define RATE_SEL_MSB 11
`define RATE_SEL_LSB 10
`define LOCK_BIT 0
`define SETUP_RESET 16'h0000

// ==========================================================
// frame layout, bits on the line, lsb first
`define CMD_WRITE_BIT 0
`define CMD_ADDR_LSB 1
`define CMD_DATA_LSB 6
`define CMD_BITS 22
`define REPLY_BITS 18

// ==========================================================
// timing
`define CLK_PERIOD_NS 5
`define BIT_TIME_NS 1000
`define PWM_PERIOD_2K_NS 500000
`define PWM_STEPS_2K 2048

`endif

// ==== core/hall_readout_pkg.sv ====
package hall_readout_pkg;

  // ==========================================================
  // signal path taps, one sample per processing cycle
  typedef struct packed {
    logic [15:0] temperature;
    logic [15:0] rawField;
    logic [15:0] factoryComp;
    logic [15:0] customerComp;
    logic [15:0] linInput;
    logic [15:0] linOutput;
    logic [15:0] scaledOutput;
    logic [15:0] outputCode;
  } tap_set_t;

  // ==========================================================
  // output line command channel
  typedef enum logic [2:0] {
    LINK_IDLE,
    LINK_START,
    LINK_RECV,
    LINK_EXEC,
    LINK_GAP,
    LINK_SEND
  } link_state_t;

  typedef logic [1:0] rate_sel_t;

endpackage

// ==== core/hall_signal_path_readout.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - once lock is set, nonvolatile writes are refused until reset reloads lockStrap; no command clears it
// - after a command the device executes it, then replies on the output pin
// - normal analog drive is off while communication is in progress
// - each sensor is selected by its own output pin; others stay silent
// - measurement taps are read-only; calibration registers are writable
// - temperature tap holds a 16-bit two's-complement value
// - raw field tap holds 16-bit signed field before compensation
// - raw field grows for south-pole fields, shrinks for opposite polarity
// - factory compensated field tap, 16-bit two's complement
// - customer compensated field tap after customer gain and offset
// - linearizer input tap, 16-bit two's complement
// - linearizer output tap after 16 setpoints, 16-bit signed
// - scaled output tap after output gain and offset, 16-bit
// - final output code tap; same value drives the output conversion
// - two 16-bit read-only production information registers
// - pulse rate selected by setup bits 11:10
// - 11=2kHz/11bit, 00=1kHz, 01=500Hz, 10=250Hz at 12 bit
// - broken supply or ground forces the output to a defined level
`include "hall_readout_regs.svh"

module hall_signal_path_readout #(
  parameter int BIT_CYCLES = `BIT_TIME_NS / `CLK_PERIOD_NS,
  parameter logic [15:0] PROD_INFO_1 = 16'h1234, // arbitrary value
  parameter logic [15:0] PROD_INFO_2 = 16'h5678  // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire hall_readout_pkg::tap_set_t taps,
  input wire logic sampleValid,
  input wire logic lockStrap,
  input wire logic [15:0] setupStrap,
  input wire logic supplyFault,
  input wire logic lineIn,
  output logic lineOut_q,
  output logic lineOe_q,
  output logic analogEnable_q,
  output logic faultForce_q,
  output logic pwmOut_q,
  output logic [15:0] outputCode_q,
  output hall_readout_pkg::rate_sel_t pulseRateSel_q,
  output logic lockState_q
);

  localparam int PWM_LSB_CYCLES = (`PWM_PERIOD_2K_NS / `CLK_PERIOD_NS) / `PWM_STEPS_2K;
  localparam int REPLY_WAIT = BIT_CYCLES + 4;
  localparam int RECV_WAIT = BIT_CYCLES + 2;

  if (BIT_CYCLES < 4 || BIT_CYCLES > 65535) begin : g_bad_bit_cycles
    $error("BIT_CYCLES out of range");
  end

  // ==========================================================
  // pin synchronisers
  logic lineS1_q, lineS2_q, lineS3_q, faultS1_q, faultS2_q;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lineS1_q <= 1'b1;
      lineS2_q <= 1'b1;
      lineS3_q <= 1'b1;
      faultS1_q <= 1'b0;
      faultS2_q <= 1'b0;
    end else begin
      lineS1_q <= lineIn;
      lineS2_q <= lineS1_q;
      lineS3_q <= lineS2_q;
      faultS1_q <= supplyFault;
      faultS2_q <= faultS1_q;
    end
  end
  logic lineFall;
  assign lineFall = lineS3_q & ~lineS2_q;

  // ==========================================================
  // readout taps
  hall_readout_pkg::tap_set_t tapsQ;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tapsQ <= '0;
      outputCode_q <= 16'h0000;
    end else if (sampleValid) begin
      tapsQ <= taps;
      outputCode_q <= taps.outputCode;
    end
  end

  // ==========================================================
  // command channel
  hall_readout_pkg::link_state_t state_q;
  logic [15:0] timer_q;
  logic [4:0] count_q;
  logic [`CMD_BITS-1:0] cmd_q;
  logic [`REPLY_BITS-1:0] reply_q;
  logic [15:0] setup_q;
  logic tick;
  logic cmdWrite;
  logic [4:0] cmdAddr;
  logic [15:0] cmdData;
  logic [15:0] readData;
  logic readOk, writeOk;

  assign tick = (timer_q == 16'h0000);
  assign cmdWrite = cmd_q[`CMD_WRITE_BIT];
  assign cmdAddr = cmd_q[`CMD_ADDR_LSB +: 5];
  assign cmdData = cmd_q[`CMD_DATA_LSB +: 16];

  always_comb begin
    readOk = 1'b1;
    case (cmdAddr)
      `REG_TEMPERATURE: readData = tapsQ.temperature;
      `REG_RAW_FIELD: readData = tapsQ.rawField;
      `REG_FACTORY_COMP: readData = tapsQ.factoryComp;
      `REG_CUSTOMER_COMP: readData = tapsQ.customerComp;
      `REG_LIN_INPUT: readData = tapsQ.linInput;
      `REG_LIN_OUTPUT: readData = tapsQ.linOutput;
      `REG_SCALED_OUTPUT: readData = tapsQ.scaledOutput;
      `REG_OUTPUT_CODE: readData = outputCode_q;
      `REG_PROD_INFO_1: readData = PROD_INFO_1;
      `REG_PROD_INFO_2: readData = PROD_INFO_2;
      `REG_CUSTOMER_SETUP: readData = setup_q;
      `REG_LOCK: readData = {15'h0000, lockState_q};
      `REG_STATUS: readData = {14'h0000, faultS2_q, lockState_q};
      default: begin
        readData = 16'h0000;
        readOk = 1'b0;
      end
    endcase
  end

  // taps, production info and status refuse writes
  assign writeOk = !lockState_q &&
    (cmdAddr == `REG_CUSTOMER_SETUP || cmdAddr == `REG_LOCK);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= hall_readout_pkg::LINK_IDLE;
      timer_q <= 16'h0000;
      count_q <= 5'h00;
      cmd_q <= '0;
      reply_q <= '0;
    end else begin
      timer_q <= tick ? 16'h0000 : timer_q - 16'h0001;
      case (state_q)
        hall_readout_pkg::LINK_IDLE: begin
          if (lineFall) begin
            state_q <= hall_readout_pkg::LINK_START;
            timer_q <= 16'(BIT_CYCLES / 2);
          end
        end
        hall_readout_pkg::LINK_START: begin
          if (tick) begin
            state_q <= lineS2_q ? hall_readout_pkg::LINK_IDLE : hall_readout_pkg::LINK_RECV;
            timer_q <= 16'(BIT_CYCLES - 1);
            count_q <= 5'h00;
          end
        end
        hall_readout_pkg::LINK_RECV: begin
          if (tick) begin
            cmd_q <= {lineS2_q, cmd_q[`CMD_BITS-1:1]};
            count_q <= count_q + 5'h01;
            timer_q <= 16'(BIT_CYCLES - 1);
            if (count_q == 5'(`CMD_BITS - 1)) begin
              state_q <= hall_readout_pkg::LINK_EXEC;
            end
          end
        end
        hall_readout_pkg::LINK_EXEC: begin
          // reply: start bit, data, ack
          reply_q <= {cmdWrite ? writeOk : readOk, readData, 1'b0};
          state_q <= hall_readout_pkg::LINK_GAP;
          timer_q <= 16'(BIT_CYCLES - 1);
        end
        hall_readout_pkg::LINK_GAP: begin
          if (tick) begin
            state_q <= hall_readout_pkg::LINK_SEND;
            timer_q <= 16'(BIT_CYCLES - 1);
            count_q <= 5'h00;
          end
        end
        hall_readout_pkg::LINK_SEND: begin
          if (tick) begin
            reply_q <= {1'b0, reply_q[`REPLY_BITS-1:1]};
            count_q <= count_q + 5'h01;
            timer_q <= 16'(BIT_CYCLES - 1);
            if (count_q == 5'(`REPLY_BITS - 1)) begin
              state_q <= hall_readout_pkg::LINK_IDLE;
            end
          end
        end
        default: state_q <= hall_readout_pkg::LINK_IDLE;
      endcase
    end
  end

  // ==========================================================
  // calibration and lock
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      setup_q <= setupStrap;
      lockState_q <= lockStrap;
    end else if (state_q == hall_readout_pkg::LINK_EXEC && cmdWrite && writeOk) begin
      if (cmdAddr == `REG_CUSTOMER_SETUP) begin
        setup_q <= cmdData;
      end
      if (cmdAddr == `REG_LOCK && cmdData[`LOCK_BIT]) begin
        lockState_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // output pin drive
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lineOut_q <= 1'b1;
      lineOe_q <= 1'b0;
      analogEnable_q <= 1'b0;
      faultForce_q <= 1'b0;
    end else begin
      lineOe_q <= (state_q == hall_readout_pkg::LINK_SEND);
      lineOut_q <= (state_q == hall_readout_pkg::LINK_SEND) ? reply_q[0] : 1'b1;
      analogEnable_q <= (state_q == hall_readout_pkg::LINK_IDLE) && !faultS2_q;
      faultForce_q <= faultS2_q;
    end
  end

  // ==========================================================
  // pulse width output
  logic [15:0] presc_q;
  logic [11:0] pwmCnt_q;
  logic [15:0] prescReload;
  logic [11:0] pwmTop;
  logic [15:0] unsignedCode;
  logic [11:0] duty;
  assign unsignedCode = outputCode_q ^ 16'h8000;
  always_comb begin
    case (pulseRateSel_q)
      2'b11: prescReload = 16'(PWM_LSB_CYCLES - 1);
      2'b00: prescReload = 16'(PWM_LSB_CYCLES - 1);
      2'b01: prescReload = 16'(2 * PWM_LSB_CYCLES - 1);
      default: prescReload = 16'(4 * PWM_LSB_CYCLES - 1);
    endcase
    pwmTop = (pulseRateSel_q == 2'b11) ? 12'h7ff : 12'hfff;
    duty = (pulseRateSel_q == 2'b11) ? {1'b0, unsignedCode[15:5]} : unsignedCode[15:4];
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pulseRateSel_q <= 2'b00;
      presc_q <= 16'h0000;
      pwmCnt_q <= 12'h000;
      pwmOut_q <= 1'b0;
    end else begin
      pulseRateSel_q <= setup_q[`RATE_SEL_MSB:`RATE_SEL_LSB];
      if (presc_q == 16'h0000) begin
        presc_q <= prescReload;
        pwmCnt_q <= (pwmCnt_q >= pwmTop) ? 12'h000 : pwmCnt_q + 12'h001;
      end else begin
        presc_q <= presc_q - 16'h0001;
      end
      pwmOut_q <= (state_q == hall_readout_pkg::LINK_IDLE) && !faultS2_q
        && (pwmCnt_q < duty);
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_lock_sticky;
    lockState_q |=> lockState_q;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared");

  property p_setup_frozen;
    lockState_q && $past(lockState_q) |-> $stable(setup_q);
  endproperty
  a_setup_frozen: assert property (p_setup_frozen) else $error("setup changed when locked");

  property p_comm_mutes;
    (state_q != hall_readout_pkg::LINK_IDLE) |=> !analogEnable_q && !pwmOut_q;
  endproperty
  a_comm_mutes: assert property (p_comm_mutes) else $error("output live in comm");

  property p_reply_follows;
    (state_q == hall_readout_pkg::LINK_EXEC) |-> ##[1:REPLY_WAIT] lineOe_q;
  endproperty
  a_reply_follows: assert property (p_reply_follows) else $error("no reply");

  property p_tap_refresh;
    sampleValid |=> tapsQ.temperature == $past(taps.temperature)
      && tapsQ.rawField == $past(taps.rawField);
  endproperty
  a_tap_refresh: assert property (p_tap_refresh) else $error("tap not refreshed");

  property p_code_feeds_output;
    sampleValid |=> outputCode_q == $past(taps.outputCode);
  endproperty
  a_code_feeds_output: assert property (p_code_feeds_output) else $error("code stale");

  property p_taps_readonly;
    (state_q == hall_readout_pkg::LINK_EXEC) && cmdWrite && (cmdAddr <= `REG_PROD_INFO_2)
      |=> !reply_q[`REPLY_BITS-1];
  endproperty
  a_taps_readonly: assert property (p_taps_readonly) else $error("tap write acked");

  property p_rate_follows;
    1'b1 |=> pulseRateSel_q == $past(setup_q[`RATE_SEL_MSB:`RATE_SEL_LSB]);
  endproperty
  a_rate_follows: assert property (p_rate_follows) else $error("rate select wrong");

  property p_fault_force;
    faultS2_q |=> faultForce_q && !analogEnable_q;
  endproperty
  a_fault_force: assert property (p_fault_force) else $error("fault not forced");

  property p_quiet_idle;
    (state_q == hall_readout_pkg::LINK_IDLE) && ($past(state_q) == hall_readout_pkg::LINK_IDLE)
      |-> !lineOe_q;
  endproperty
  a_quiet_idle: assert property (p_quiet_idle) else $error("line driven idle");

  property p_recv_bounded;
    (state_q == hall_readout_pkg::LINK_RECV) |-> ##[1:RECV_WAIT] (count_q != $past(count_q))
      || (state_q != hall_readout_pkg::LINK_RECV);
  endproperty
  a_recv_bounded: assert property (p_recv_bounded) else $error("receive stalled");

  c_write_setup: cover property ((state_q == hall_readout_pkg::LINK_EXEC) && cmdWrite
    && writeOk && cmdAddr == `REG_CUSTOMER_SETUP);
  c_lock_set: cover property (!lockState_q ##1 lockState_q);
  c_read_reply: cover property ((state_q == hall_readout_pkg::LINK_SEND) && !cmdWrite);
  c_rate_2k: cover property (pulseRateSel_q == 2'b11);

endmodule // hall_signal_path_readout

// ==== verification/line_programmer_model.sv ====
`timescale 1ns/1ps
module line_programmer_model #(
  parameter int BIT = 8
) (
  input wire logic clk_sys,
  input wire logic lineOe,
  input wire logic lineOut,
  output logic lineLevel,
  output logic replyValid,
  output logic [17:0] reply
);
  logic drv = 1'b1;
  // ====
  // wire level, pulled high when nobody drives
  assign lineLevel = lineOe ? lineOut : drv;
  initial replyValid = 1'b0;
  initial reply = 18'h0;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // ====
  // frame on this sensor's own line, then collect the reply
  task automatic send_frame(input logic wr, input logic [4:0] idx, input logic [15:0] data,
      input int gap);
    logic [21:0] frame;
    int n;
    frame = {data, idx, wr};
    tick(gap);
    drv = 1'b0;
    tick(BIT);
    for (int i = 0; i < 22; i++) begin
      drv = frame[i];
      tick(BIT);
    end
    drv = 1'b1;
    n = 0;
    while (lineOe !== 1'b1 && n < 4000) begin
      tick(1);
      n++;
    end
    tick(BIT / 2);
    for (int i = 0; i < 18; i++) begin
      reply[i] = lineLevel;
      if (i < 17) tick(BIT);
    end
    n = 0;
    while (lineOe !== 1'b0 && n < 4000) begin
      tick(1);
      n++;
    end
    replyValid = 1'b1;
    tick(1);
    replyValid = 1'b0;
  endtask
endmodule // line_programmer_model

// ==== verification/tb_hall_signal_path_readout.sv ====
`timescale 1ns/1ps
module tb_hall_signal_path_readout;
  localparam int BIT = 8;
  localparam logic [15:0] INFO1 = 16'h3a5c; // arbitrary value
  localparam logic [15:0] INFO2 = 16'hc3a5; // arbitrary value
  logic clk_sys = 1'b0;
  logic reset, sampleValid, lockStrap, supplyFault, lineLevel, replyValid;
  logic lineOut_q, lineOe_q, analogEnable_q, faultForce_q, pwmOut_q, lockState_q;
  logic [15:0] setupStrap, outputCode_q, prev, d;
  logic [17:0] reply;
  hall_readout_pkg::tap_set_t taps, cur;
  hall_readout_pkg::rate_sel_t pulseRateSel_q;
  logic [1:0] rates [4] = '{2'b11, 2'b00, 2'b01, 2'b10};
  logic [16:0] expQ [$];
  logic pwmSeen;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  integer seed = 32'h4c01cbba;

  hall_signal_path_readout #(.BIT_CYCLES(BIT), .PROD_INFO_1(INFO1), .PROD_INFO_2(INFO2))
      u_hall_signal_path_readout (.clk_sys(clk_sys), .reset(reset), .taps(taps),
      .sampleValid(sampleValid), .lockStrap(lockStrap), .setupStrap(setupStrap),
      .supplyFault(supplyFault), .lineIn(lineLevel), .lineOut_q(lineOut_q),
      .lineOe_q(lineOe_q), .analogEnable_q(analogEnable_q), .faultForce_q(faultForce_q),
      .pwmOut_q(pwmOut_q), .outputCode_q(outputCode_q), .pulseRateSel_q(pulseRateSel_q),
      .lockState_q(lockState_q));
  line_programmer_model #(.BIT(BIT)) u_line_programmer_model (.clk_sys(clk_sys),
      .lineOe(lineOe_q), .lineOut(lineOut_q), .lineLevel(lineLevel),
      .replyValid(replyValid), .reply(reply));

  always #2.5 clk_sys = ~clk_sys;

  // ====
  // compare and close
  task automatic compare_value(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic compare_reply(input logic [16:0] got, input logic [16:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: reply ack/data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ====
  // stimulus helpers
  task automatic expect_frame(input logic wr, input logic [4:0] idx, input logic [15:0] data,
      input logic [15:0] expData, input logic expAck);
    expQ.push_back({expAck, expData});
    u_line_programmer_model.send_frame(wr, idx, data, 1 + {$random(seed)} % 4);
  endtask
  task automatic new_sample();
    @(posedge clk_sys);
    #1;
    cur = {$random(seed), $random(seed), $random(seed), $random(seed)};
    taps = cur;
    sampleValid = 1'b1;
    @(posedge clk_sys);
    #1;
    sampleValid = 1'b0;
    compare_value(outputCode_q, cur.outputCode);
  endtask
  task automatic set_code(input logic [15:0] code);
    @(posedge clk_sys);
    #1;
    taps.outputCode = code;
    sampleValid = 1'b1;
    @(posedge clk_sys);
    #1;
    sampleValid = 1'b0;
  endtask
  task automatic check_taps();
    for (int i = 0; i < 8; i++) begin
      expect_frame(1'b0, i[4:0], 16'h0000, cur[127 - 16 * i -: 16], 1'b1);
      expect_frame(1'b1, i[4:0], 16'($random(seed)), cur[127 - 16 * i -: 16], 1'b0);
    end
  endtask

  // ====
  // watchers
  always @(posedge clk_sys) begin
    if (replyValid === 1'b1) begin
      compare_value({15'h0, reply[0]}, 16'h0000);
      if (expQ.size() == 0)
        compare_reply({reply[17], reply[16:1]}, 17'h1ffff);
      else
        compare_reply({reply[17], reply[16:1]}, expQ.pop_front());
    end
  end
  always @(posedge lineOe_q) begin
    #1;
    compare_value({14'h0, analogEnable_q, pwmOut_q}, 16'h0000);
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      $display("mismatch at %0t: run did not finish", $time);
      wrap_up();
    end
  end

  // ====
  // main sequence
  initial begin
    reset = 1'b1;
    taps = '0;
    sampleValid = 1'b0;
    lockStrap = 1'b0;
    setupStrap = 16'h0c00;
    supplyFault = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    compare_value({14'h0, pulseRateSel_q}, 16'h0003);
    compare_value({15'h0, lockState_q}, 16'h0000);
    compare_value({15'h0, analogEnable_q}, 16'h0001);
    new_sample();
    check_taps();
    new_sample();
    check_taps();
    expect_frame(1'b0, 5'h08, 16'h0000, INFO1, 1'b1);
    expect_frame(1'b1, 5'h09, 16'hffff, INFO2, 1'b0);
    expect_frame(1'b0, 5'h09, 16'h0000, INFO2, 1'b1);
    prev = 16'h0c00;
    for (int r = 0; r < 4; r++) begin
      d = 16'($random(seed));
      d[11:10] = rates[r];
      expect_frame(1'b1, 5'h0a, d, prev, 1'b1);
      compare_value({14'h0, pulseRateSel_q}, {14'h0, rates[r]});
      prev = d;
    end
    expect_frame(1'b0, 5'h1f, 16'h0000, 16'h0000, 1'b0);
    expect_frame(1'b1, 5'h0b, 16'h0001, 16'h0000, 1'b1);
    expect_frame(1'b0, 5'h0b, 16'h0000, 16'h0001, 1'b1);
    compare_value({15'h0, lockState_q}, 16'h0001);
    expect_frame(1'b1, 5'h0a, ~prev, prev, 1'b0);
    expect_frame(1'b0, 5'h0a, 16'h0000, prev, 1'b1);
    expect_frame(1'b1, 5'h0b, 16'h0000, 16'h0001, 1'b0);
    expect_frame(1'b0, 5'h0c, 16'h0000, 16'h0001, 1'b1);
    supplyFault = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    compare_value({14'h0, faultForce_q, analogEnable_q}, 16'h0002);
    supplyFault = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    compare_value({14'h0, faultForce_q, analogEnable_q}, 16'h0001);
    set_code(16'h7fff);
    repeat (4) @(posedge clk_sys);
    #1;
    pwmSeen = pwmOut_q;
    repeat (200) @(posedge clk_sys);
    #1;
    compare_value({15'h0, pwmSeen | pwmOut_q}, 16'h0001);
    set_code(16'h8000);
    repeat (4) @(posedge clk_sys);
    #1;
    compare_value({15'h0, pwmOut_q}, 16'h0000);
    compare_value(16'(expQ.size()), 16'h0000);
    wrap_up();
  end
endmodule // tb_hall_signal_path_readout
